// ==== hw/dram_bank_pkg.sv ====
// Package of the DRAM bank, row and read burst block: command encodings,
// carrier structs, field positions and burst constants.
// Assumes a single clock domain on the device side, clk_in.
package dram_bank_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int NUM_BANKS  = 8;
  localparam int BANK_W     = 3;
  localparam int ROW_W      = 16;
  localparam int COL_W      = 10;
  localparam int ADDR_W     = 16;
  localparam int DQ_W       = 8;

  // ****************************************************************
  // Address field positions
  // ****************************************************************
  localparam int ADDR_AP_BIT = 10;
  localparam int ADDR_BL_BIT = 12;

  // ****************************************************************
  // Burst and latency
  // ****************************************************************
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [3:0] BEATS_BL8 = 4'h8;
  localparam logic [3:0] BEATS_BC4 = 4'h4;
  localparam int         MAX_RL    = 32;
  localparam int         LAT_W     = 5;
  localparam int         TRP_W     = 6;

  // Command pins as registered on a rising link clock edge
  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } cmd_bus_t;

  // Column read request handed to the storage core
  typedef struct packed {
    logic              valid;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0]  row;
    logic [COL_W-1:0]  col;
    logic              chop;
  } rd_req_t;

  // Read latency pipeline entry
  typedef struct packed {
    logic valid;
    logic chop;
  } lat_slot_t;

  typedef enum logic [3:0] {
    CMD_NONE  = 4'h1,
    CMD_ACT   = 4'h2,
    CMD_PRE   = 4'h4,
    CMD_RDWR  = 4'h8
  } cmd_kind_t;

  typedef enum logic [2:0] {
    FR_IDLE  = 3'h1,
    FR_PRE   = 3'h2,
    FR_BURST = 3'h4
  } frame_state_t;

endpackage

// ==== hw/dram_bank_read.sv ====
// Bank state, row activation, precharge and read burst framing of a DDR3
// style SDRAM, with the read data FIFO between storage core and DQ pins.
// Assumes the controller clock ck_in is slow against clk_in (several clk_in
// cycles per half period) and that the command pins settle well before the
// rising ck edge.
// Operation
// - An activate command opens the row given on the address inputs in the bank given on the bank inputs.
// - An open row stays open for column accesses until a precharge reaches its bank.
// - A precharge closes the open row of one bank or of all banks.
// - A precharged bank is idle and takes no read or write until a row is activated.
// - A precharge to an idle or already precharging bank is legal.
// - The precharge period runs from the latest precharge to a bank.
// - Address bit 12 picks a chopped 4 beat burst when low and an 8 beat burst when high; the code applies it only with mode bits 01.
// - Address bit 12 is never part of the column address.
// - Mode bits 00 or 01 with bit 12 high give an 8 beat burst.
// - Read timing holds only with the delay locked loop enabled and locked.
// - Rising strobe edges may move within the allowed window inside a burst.
// - Read beats are aligned to both strobe edges.
`timescale 1ns/1ps

module read_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic      [WIDTH-1:0] out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0]   count;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count != DEPTH[PTR_W:0]);
  assign out_valid_out = (count != '0);
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_ready_in & out_valid_out;
  assign out_data_out  = mem[rd_ptr];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end
endmodule // read_fifo

module dram_bank_read #(
  parameter int TRP_CK     = 2,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                       clk_in,
  input  wire logic                       sys_rst_in,
  input  wire logic                       ck_in,
  input  wire dram_bank_pkg::cmd_bus_t    cmd_in,
  input  wire logic [1:0]                 mode_bl_in,
  input  wire logic [dram_bank_pkg::LAT_W-1:0] al_in,
  input  wire logic [dram_bank_pkg::LAT_W-1:0] cl_in,
  input  wire logic                       dll_en_in,
  input  wire logic                       dll_locked_in,
  output dram_bank_pkg::rd_req_t          rd_req_out,
  input  wire logic [dram_bank_pkg::DQ_W-1:0] core_data_in,
  input  wire logic                       core_valid_in,
  output logic                            core_ready_out,
  output logic [dram_bank_pkg::DQ_W-1:0]  dq_out,
  output logic                            dq_oe_out,
  output logic                            dqs_out,
  output logic                            dqs_n_out,
  output logic                            dqs_oe_out,
  output logic [dram_bank_pkg::NUM_BANKS-1:0] bank_open_out,
  output logic [dram_bank_pkg::NUM_BANKS-1:0] bank_busy_out,
  output logic                            cmd_err_out,
  output logic                            underrun_out
);
  import dram_bank_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0]   ck_sync;
  cmd_bus_t     cmd_s1;
  cmd_bus_t     cmd_s2;
  cmd_bus_t     cmd_s3;
  logic         ck_level;
  logic         ck_rise;
  logic         ck_fall;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ck_sync <= 3'h0;
    end else begin
      ck_sync <= {ck_sync[1:0], ck_in};
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cmd_s1 <= '1;
      cmd_s2 <= '1;
      cmd_s3 <= '1;
    end else begin
      cmd_s1 <= cmd_in;
      cmd_s2 <= cmd_s1;
      cmd_s3 <= cmd_s2;
    end
  end

  // A level change counts only once the last two stages agree
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ck_level <= 1'b0;
    end else if (ck_sync[1] == ck_sync[2]) begin
      ck_level <= ck_sync[2];
    end
  end

  assign ck_rise = (ck_sync[1] == ck_sync[2]) & ck_sync[2] & ~ck_level;
  assign ck_fall = (ck_sync[1] == ck_sync[2]) & ~ck_sync[2] & ck_level;

  // ****************************************************************
  // Command decode
  // ****************************************************************
  function automatic cmd_kind_t decode(input cmd_bus_t c);
    if (c.cs_n) begin
      decode = CMD_NONE;
    end else begin
      case ({c.ras_n, c.cas_n, c.we_n})
        3'h3:    decode = CMD_ACT;
        3'h2:    decode = CMD_PRE;
        3'h5,
        3'h4:    decode = CMD_RDWR;
        default: decode = CMD_NONE;
      endcase
    end
  endfunction

  cmd_kind_t                kind;
  logic [NUM_BANKS-1:0]     bank_sel;
  logic                     is_read;
  logic                     ap;
  logic                     chop;
  logic                     dll_ok;

  assign kind     = ck_rise ? decode(cmd_s3) : CMD_NONE;
  assign bank_sel = NUM_BANKS'(1) << cmd_s3.ba;
  assign is_read  = cmd_s3.we_n;
  assign ap       = cmd_s3.addr[ADDR_AP_BIT];
  assign dll_ok   = dll_en_in & dll_locked_in;

  // Fixed 8 and on the fly with bit 12 high give 8 beats; else chop
  always_comb begin
    case (mode_bl_in)
      BL_FIXED8: chop = 1'b0;
      BL_OTF:    chop = ~cmd_s3.addr[ADDR_BL_BIT];
      default:   chop = 1'b1;
    endcase
  end

  // ****************************************************************
  // Bank state
  // ****************************************************************
  logic [ROW_W-1:0] open_row [NUM_BANKS];
  logic [TRP_W-1:0] trp_cnt  [NUM_BANKS];
  logic [NUM_BANKS-1:0] pre_hit;
  logic [NUM_BANKS-1:0] act_bad;
  logic             rd_bad;

  genvar b;
  generate
    for (b = 0; b < NUM_BANKS; b++) begin : g_bank
      // All-bank form when bit 10 is high
      assign pre_hit[b] = ((kind == CMD_PRE) & (ap | bank_sel[b])) |
                          ((kind == CMD_RDWR) & ap & bank_sel[b] &
                           ~rd_bad);
      assign act_bad[b] = bank_sel[b] &
                          (bank_open_out[b] | bank_busy_out[b]);

      always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
          bank_open_out[b] <= 1'b0;
        end else if (pre_hit[b]) begin
          bank_open_out[b] <= 1'b0;
        end else if ((kind == CMD_ACT) & bank_sel[b] & ~act_bad[b]) begin
          bank_open_out[b] <= 1'b1;
        end
      end

      always_ff @(posedge clk_in) begin
        if ((kind == CMD_ACT) & bank_sel[b] & ~act_bad[b]) begin
          open_row[b] <= cmd_s3.addr;
        end
      end

      // Restarted by every precharge, so the latest one sets the end
      always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
          trp_cnt[b] <= '0;
        end else if (pre_hit[b]) begin
          trp_cnt[b] <= TRP_W'(TRP_CK);
        end else if (ck_rise & (trp_cnt[b] != '0)) begin
          trp_cnt[b] <= trp_cnt[b] - 1'b1;
        end
      end

      assign bank_busy_out[b] = (trp_cnt[b] != '0);
    end
  endgenerate

  // Accesses to idle banks and reads without a locked loop are flagged and dropped; others proceed
  assign rd_bad = ~bank_open_out[cmd_s3.ba] | (is_read & ~dll_ok);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cmd_err_out <= 1'b0;
    end else begin
      cmd_err_out <= ((kind == CMD_ACT) & |act_bad) |
                     ((kind == CMD_RDWR) & rd_bad);
    end
  end

  // ****************************************************************
  // Read request to the core
  // ****************************************************************
  logic rd_go;

  assign rd_go = (kind == CMD_RDWR) & is_read & ~rd_bad;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rd_req_out <= '0;
    end else begin
      rd_req_out.valid <= rd_go;
      if (rd_go) begin
        rd_req_out.bank <= cmd_s3.ba;
        rd_req_out.row  <= open_row[cmd_s3.ba];
        rd_req_out.col  <= cmd_s3.addr[COL_W-1:0];
        rd_req_out.chop <= chop;
      end
    end
  end

  // ****************************************************************
  // Read latency pipeline, one slot per link clock cycle
  // ****************************************************************
  lat_slot_t        lat_pipe [MAX_RL];
  logic [LAT_W-1:0] rl_m1;
  logic [LAT_W-1:0] rl_m2;
  lat_slot_t        tap_pre;
  lat_slot_t        tap_go;

  assign rl_m1   = al_in + cl_in - 1'b1;
  assign rl_m2   = al_in + cl_in - LAT_W'(2);
  assign tap_go  = lat_pipe[rl_m1];
  assign tap_pre = lat_pipe[rl_m2];

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < MAX_RL; i++) begin
        lat_pipe[i] <= '0;
      end
    end else if (ck_rise) begin
      lat_pipe[0] <= '{valid: rd_go, chop: chop};
      for (int i = 1; i < MAX_RL; i++) begin
        lat_pipe[i] <= lat_pipe[i-1];
      end
    end
  end

  // ****************************************************************
  // Burst framing
  // ****************************************************************
  frame_state_t     state;
  logic [3:0]       beats_left;
  logic             edge_any;
  logic             beat;
  logic             start;
  logic [DQ_W-1:0]  fifo_data;
  logic             fifo_valid;

  assign edge_any = ck_rise | ck_fall;
  assign start    = ck_rise & tap_go.valid;
  assign beat     = start |
                    (edge_any & (state == FR_BURST) & (beats_left != '0));

  read_fifo #(
    .WIDTH (DQ_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .in_data_in    (core_data_in),
    .in_valid_in   (core_valid_in),
    .in_ready_out  (core_ready_out),
    .out_data_out  (fifo_data),
    .out_valid_out (fifo_valid),
    .out_ready_in  (beat)
  );

  // Back to back reads at four cycle spacing reload without a gap
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state      <= FR_IDLE;
      beats_left <= 4'h0;
    end else begin
      case (state)
        FR_IDLE: begin
          if (start) begin
            state      <= FR_BURST;
            beats_left <= (tap_go.chop ? BEATS_BC4 : BEATS_BL8) - 1'b1;
          end else if (ck_rise & tap_pre.valid) begin
            state <= FR_PRE;
          end
        end
        FR_PRE: begin
          if (start) begin
            state      <= FR_BURST;
            beats_left <= (tap_go.chop ? BEATS_BC4 : BEATS_BL8) - 1'b1;
          end
        end
        FR_BURST: begin
          if (start) begin
            beats_left <= (tap_go.chop ? BEATS_BC4 : BEATS_BL8) - 1'b1;
          end else if (beat) begin
            beats_left <= beats_left - 1'b1;
          end else if (ck_rise & (beats_left == '0)) begin
            state <= FR_IDLE;
          end
        end
        default: state <= FR_IDLE;
      endcase
    end
  end

  // Data changes one clk_in cycle before each strobe edge, so beats are edge aligned
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      dq_out       <= '0;
      underrun_out <= 1'b0;
    end else begin
      underrun_out <= beat & ~fifo_valid;
      if (beat) begin
        dq_out <= fifo_valid ? fifo_data : '0;
      end
    end
  end

  // Strobe follows the sampled clock; its phase is not held fixed
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      dqs_out    <= 1'b0;
      dqs_oe_out <= 1'b0;
      dq_oe_out  <= 1'b0;
    end else begin
      dqs_out    <= (state == FR_BURST) ? ck_level : 1'b0;
      dqs_oe_out <= (state != FR_IDLE) | start;
      dq_oe_out  <= (state == FR_BURST) | start;
    end
  end

  assign dqs_n_out = ~dqs_out;

endmodule // dram_bank_read

// ==== dv/ctrl_model.sv ====
// Controller model: free-running link clock and one-command driver.
// Assumes only the bench main sequence calls issue().
`timescale 1ns/1ps
module ctrl_model
  import dram_bank_pkg::*;
(
  input  wire logic clk_in,
  output logic      ck_out,
  output cmd_bus_t  cmd_out
);
  int n_rise;
  int stamp;

  initial begin
    ck_out  = 1'b0;
    cmd_out = cmd_bus_t'({4'hF, 3'h0, 16'h0000});
    n_rise  = 0;
    #37;
    forever begin
      #100 ck_out = ~ck_out;
      if (ck_out) n_rise++;
    end
  end

  // Set a whole ck period ahead so the synchronised copy is settled
  task automatic issue(input cmd_bus_t c);
    @(posedge ck_out);
    @(negedge clk_in);
    cmd_out = c;
    @(posedge ck_out);
    @(negedge ck_out);
    stamp = n_rise;
    @(negedge clk_in);
    // Deselected lines show junk, never the last command
    cmd_out = cmd_bus_t'({4'hF, ~c.ba, ~c.addr});
  endtask
endmodule // ctrl_model

// ==== dv/dram_bank_props.sv ====
// Checker of the bank and read burst block, bound to its ports.
// Assumes one clock domain, clk_in, with sync reset sys_rst_in.
`timescale 1ns/1ps
module dram_bank_props
  import dram_bank_pkg::*;
(
  input wire logic                 clk_in,
  input wire logic                 sys_rst_in,
  input wire logic                 dll_en_in,
  input wire logic                 dll_locked_in,
  input wire rd_req_t              rd_req_out,
  input wire logic                 dq_oe_out,
  input wire logic                 dqs_out,
  input wire logic                 dqs_n_out,
  input wire logic                 dqs_oe_out,
  input wire logic [NUM_BANKS-1:0] bank_open_out,
  input wire logic [NUM_BANKS-1:0] bank_busy_out,
  input wire logic                 cmd_err_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  req_open_a:
    assert property (rd_req_out.valid |->
      (($past(bank_open_out) >> rd_req_out.bank) & 8'h01) != 8'h00)
    else $error("read request to a closed bank");
  req_dll_a:
    assert property (rd_req_out.valid |->
      $past(dll_en_in) && $past(dll_locked_in))
    else $error("read request without locked loop");
  open_busy_a:
    assert property ((bank_open_out & bank_busy_out) == 8'h00)
    else $error("bank open while precharging");
  err_pulse_a:
    assert property (cmd_err_out |=> !cmd_err_out)
    else $error("error flag longer than one cycle");
  strobe_pair_a:
    assert property (dqs_oe_out |-> dqs_n_out == !dqs_out)
    else $error("strobe pair not complementary");
  data_strobe_a:
    assert property (dq_oe_out |-> dqs_oe_out)
    else $error("data driven without strobe");
  preamble_a:
    assert property ($rose(dqs_oe_out) |-> !dqs_out [*6])
    else $error("preamble strobe not low");
  first_beat_a:
    assert property ($rose(dqs_oe_out) |-> ##[6:10] $rose(dq_oe_out))
    else $error("first beat not one ck after preamble");
  burst_min_a:
    assert property ($rose(dq_oe_out) |-> dq_oe_out [*8])
    else $error("burst shorter than one ck");
endmodule // dram_bank_props

bind dram_bank_read dram_bank_props u_dram_bank_props (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .dll_en_in(dll_en_in),
  .dll_locked_in(dll_locked_in), .rd_req_out(rd_req_out),
  .dq_oe_out(dq_oe_out), .dqs_out(dqs_out), .dqs_n_out(dqs_n_out),
  .dqs_oe_out(dqs_oe_out), .bank_open_out(bank_open_out),
  .bank_busy_out(bank_busy_out), .cmd_err_out(cmd_err_out));

// ==== dv/dram_bank_read_test.sv ====
// Self-checking bench of the bank and read burst block.
// Assumes the controller model in ctrl_model.sv and TRP_CK of 3.
`timescale 1ns/1ps
module dram_bank_read_test;
  import dram_bank_pkg::*;
  localparam logic [2:0] ACT = 3'h3;
  localparam logic [2:0] PRE = 3'h2;
  localparam logic [2:0] RD  = 3'h5;
  logic                 clk_in     = 1'b0;
  logic                 sys_rst_in = 1'b1;
  logic [1:0]           mode_bl    = 2'h1;
  logic [LAT_W-1:0]     al         = 5'h00;
  logic [LAT_W-1:0]     cl         = 5'h05;
  logic                 dll_locked = 1'b1;
  logic                 dll_en     = 1'b1;
  logic [DQ_W-1:0]      core_data  = 8'h00;
  logic                 core_valid = 1'b0;
  logic                 last_dqs   = 1'b0;
  logic                 ck, core_ready, dq_oe, dqs, dqs_n, dqs_oe;
  logic                 cmd_err, underrun;
  logic [DQ_W-1:0]      dq;
  logic [NUM_BANKS-1:0] open, busy;
  cmd_bus_t             cmd;
  rd_req_t              req, last_req;
  logic [DQ_W-1:0]      beats[$];
  int failures = 0;
  int checked  = 0;
  int errs     = 0;
  int unds     = 0;

  always #12.5 clk_in = ~clk_in;

  ctrl_model u_ctrl_model (.clk_in(clk_in), .ck_out(ck), .cmd_out(cmd));

  dram_bank_read #(.TRP_CK(3), .FIFO_DEPTH(8)) u_dram_bank_read (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ck_in(ck), .cmd_in(cmd),
    .mode_bl_in(mode_bl), .al_in(al), .cl_in(cl), .dll_en_in(dll_en),
    .dll_locked_in(dll_locked), .rd_req_out(req),
    .core_data_in(core_data), .core_valid_in(core_valid),
    .core_ready_out(core_ready), .dq_out(dq), .dq_oe_out(dq_oe),
    .dqs_out(dqs), .dqs_n_out(dqs_n), .dqs_oe_out(dqs_oe),
    .bank_open_out(open), .bank_busy_out(busy), .cmd_err_out(cmd_err),
    .underrun_out(underrun));

  // ****************************************************************
  // Monitor: a beat is taken on every strobe level change
  // ****************************************************************
  always @(negedge clk_in) begin
    if (cmd_err === 1'b1) errs++;
    if (underrun === 1'b1) unds++;
    if (req.valid === 1'b1) last_req = req;
    if (dq_oe !== 1'b1) last_dqs = 1'b0;
    else if (dqs !== last_dqs) begin
      beats.push_back(dq);
      last_dqs = dqs;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  function automatic cmd_bus_t mk(input logic [2:0] k,
                                  input logic [2:0] b,
                                  input logic [15:0] a);
    return cmd_bus_t'({1'b0, k, b, a});
  endfunction

  task automatic settle(input int n);
    repeat (n) @(posedge ck);
    repeat (8) @(negedge clk_in);
  endtask

  task automatic push(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_in);
      core_data  = 8'hA0 + 8'(i);
      core_valid = 1'b1;
    end
    @(negedge clk_in);
    core_valid = 1'b0;
  endtask

  task automatic t_reset;
    chk("open", 8'h00, open);
    chk("busy", 8'h00, busy);
    chk("oe", 2'h0, {dq_oe, dqs_oe});
    chk("dqs_n", 1'b1, dqs_n);
    chk("core_ready", 1'b1, core_ready);
  endtask

  task automatic t_act;
    u_ctrl_model.issue(mk(ACT, 3'h2, 16'h1234));
    u_ctrl_model.issue(mk(ACT, 3'h5, 16'hBEEF));
    settle(0);
    chk("open", 8'h24, open);
  endtask

  task automatic t_read(input logic [1:0] m, input logic a12, input int a,
                        input int nb, input int np, input int nv);
    int k;
    int rl;
    mode_bl = m;
    al      = 5'(a);
    beats.delete();
    u_ctrl_model.issue(mk(RD, 3'h2, {3'h0, a12, 2'h0, 10'h2A5}));
    push(np);
    for (k = 0; k < 600 && dq_oe !== 1'b1; k++) @(negedge clk_in);
    rl = u_ctrl_model.n_rise - u_ctrl_model.stamp;
    for (k = 0; k < 600 && dq_oe === 1'b1; k++) @(negedge clk_in);
    chk("latency", a + 5, rl);
    chk("beats", nb, beats.size());
    for (k = 0; k < nb; k++)
      chk("beat", k < nv ? 8'hA0 + k : 8'h00, beats[k]);
    chk("bank", 3'h2, last_req.bank);
    chk("col", 10'h2A5, last_req.col);
    chk("row", 16'h1234, last_req.row);
    chk("chop", nb == 4, last_req.chop);
  endtask

  task automatic t_reads;
    push(8);
    chk("fifo_full", 1'b0, core_ready);
    t_read(2'h1, 1'b1, 0, 8, 0, 8);
    t_read(2'h1, 1'b0, 4, 4, 4, 4);
    t_read(2'h0, 1'b0, 0, 8, 8, 8);
    t_read(2'h2, 1'b1, 0, 4, 0, 0);
    chk("underrun", 1'b1, unds != 0);
  endtask

  task automatic t_pre;
    int e0;
    e0 = errs;
    u_ctrl_model.issue(mk(PRE, 3'h5, 16'h0000));
    repeat (4) @(negedge clk_in);
    chk("open", 8'h04, open);
    chk("busy", 8'h20, busy);
    u_ctrl_model.issue(mk(PRE, 3'h5, 16'h0000));
    settle(1);
    chk("busy_restart", 8'h20, busy);
    settle(2);
    chk("busy_end", 8'h00, busy);
    u_ctrl_model.issue(mk(PRE, 3'h0, 16'h0400));
    repeat (4) @(negedge clk_in);
    chk("open_all", 8'h00, open);
    chk("busy_all", 8'hFF, busy);
    // Too early for the precharge period, so the device refuses it
    u_ctrl_model.issue(mk(ACT, 3'h2, 16'h0055));
    settle(0);
    chk("errors", e0 + 1, errs);
  endtask

  task automatic t_refuse;
    int e0;
    settle(4);
    e0 = errs;
    u_ctrl_model.issue(mk(RD, 3'h2, 16'h0000));
    u_ctrl_model.issue(mk(ACT, 3'h2, 16'h1234));
    u_ctrl_model.issue(mk(ACT, 3'h2, 16'h0077));
    dll_locked = 1'b0;
    u_ctrl_model.issue(mk(RD, 3'h2, 16'h1000));
    dll_locked = 1'b1;
    dll_en     = 1'b0;
    u_ctrl_model.issue(mk(RD, 3'h2, 16'h1000));
    // Long enough that a wrongly taken read would be bursting now
    settle(5);
    dll_en = 1'b1;
    chk("errors", e0 + 4, errs);
    chk("open", 8'h04, open);
    chk("no_burst", 1'b0, dqs_oe);
  endtask

  // Auto precharge on one bank, then a read of the other bank five ck after it
  task automatic t_auto;
    int e0;
    e0      = errs;
    mode_bl = 2'h1;
    beats.delete();
    push(8);
    u_ctrl_model.issue(mk(ACT, 3'h5, 16'hBEEF));
    u_ctrl_model.issue(mk(RD, 3'h2, 16'h0410));
    repeat (4) @(negedge clk_in);
    chk("row_kept", 16'h1234, last_req.row);
    chk("open_ap", 8'h20, open);
    chk("busy_ap", 8'h04, busy);
    settle(2);
    u_ctrl_model.issue(mk(RD, 3'h5, 16'h0021));
    settle(12);
    chk("errors", e0, errs);
    chk("beats", 8, beats.size());
    for (int k = 0; k < 8; k++)
      chk("beat", 8'hA0 + k, beats[k]);
    chk("bank", 3'h5, last_req.bank);
    chk("row", 16'hBEEF, last_req.row);
    chk("col", 10'h021, last_req.col);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #1_000_000;
    failures++;
    test_done;
  end

  initial begin
    repeat (8) @(negedge clk_in);
    sys_rst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    t_reset;
    t_act;
    t_reads;
    t_pre;
    t_refuse;
    t_auto;
    test_done;
  end
endmodule // dram_bank_read_test
